// ==== rtl/tbu_pkg.sv ====
//--------------------------------------------------------------
// Functional notes
// [RULE1] overflow flag at modulo; irq needs enable
// [RULE2] each channel flag gated by own enable
// [RULE3] wait: keeps counting, irq wakes processor
// [RULE4] stop mode freezes counter and registers
// [RULE5] break freezes counter, drops input captures
// [RULE6] clear-enable low: break accesses keep flags
// [RULE7] clear-enable high: flags clear during break
// [RULE8] overflow flag: read-then-write-zero clears
// [RULE9] halt bit stops counter; set at reset
// [RULE10] halt bit inhibits input captures
// [RULE11] counter reset clears counter and prescaler
// [RULE12] halt plus reset holds counter at zero
// [RULE13] prescale select divides 1 to 64
// [RULE14] high read latches low byte once
// [RULE15] reset and counter reset clear count
// [RULE16] match modulo sets flag, restarts count
// [RULE17] modulo high write inhibits overflow until low
// [RULE18] reset sets modulo registers to all ones
// [RULE19] channel flag on edge or compare match
// [RULE20] channel flag two-step clear, events win
// [RULE21] channels capture or compare, buffered pair
// [RULE22] software unhalts before clearing a flag
// [RULE23] software resets counter before modulo write
// [RULE24] reset clears channel irq enables
// [RULE25] 16-bit counter steps on prescaled tick
// [RULE26] level irq until flag or enable clears
//--------------------------------------------------------------
package tbu_pkg;
   // byte addresses of the word-wide register slots
   localparam logic [7:0] TBU_A_SC = 8'h00;
   localparam logic [7:0] TBU_A_CNTH = 8'h04;
   localparam logic [7:0] TBU_A_CNTL = 8'h08;
   localparam logic [7:0] TBU_A_MODH = 8'h0C;
   localparam logic [7:0] TBU_A_MODL = 8'h10;
   localparam logic [7:0] TBU_A_CH0SC = 8'h14;
   localparam logic [7:0] TBU_A_CH1SC = 8'h18;
   localparam logic [7:0] TBU_A_CH0H = 8'h1C;
   localparam logic [7:0] TBU_A_CH0L = 8'h20;
   localparam logic [7:0] TBU_A_CH1H = 8'h24;
   localparam logic [7:0] TBU_A_CH1L = 8'h28;
   // field positions inside a written byte
   localparam int unsigned TBU_B_FLAG = 7;
   localparam int unsigned TBU_B_RST = 4;
   localparam int unsigned TBU_B_HALT = 5;
   // reset values
   localparam logic [7:0] TBU_SC_RESET = 8'h20;
   localparam logic [7:0] TBU_CH_RESET = 8'h00;
   localparam logic [15:0] TBU_MOD_RESET = 16'hFFFF;
   localparam logic [15:0] TBU_CNT_ZERO = 16'h0000;
   // prescaler: six bits reach divide by 64
   localparam int unsigned TBU_PW = 6;
   localparam logic [2:0] TBU_PS_UNUSED = 3'h7;
   // timer status and control byte
   typedef struct packed {
      logic flag;
      logic irq_en;
      logic halt;
      logic rst;
      logic rsv;
      logic [2:0] ps;
   } tbu_sc_t;
   // channel status and control byte
   typedef struct packed {
      logic flag;
      logic irq_en;
      logic buf_mode;
      logic mode_a;
      logic [1:0] edge_sel;
      logic tov;
      logic max;
   } tbu_ch_t;
endpackage

// ==== rtl/tbu_timer.sv ====
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module tbu_timer
   import tbu_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_stop,
   input wire logic i_break,
   input wire logic i_break_clear_enable,
   input wire logic [1:0] i_channel_pin,
   output logic o_overflow_irq,
   output logic [1:0] o_channel_irq,
   output logic o_wakeup
);

   //-----------------------------------------------------------
   // state
   //-----------------------------------------------------------
   tbu_sc_t sc_reg, sc_next; // status and control
   logic [15:0] cnt_reg, cnt_next; // main counter
   logic [TBU_PW-1:0] presc_reg, presc_next; // prescaler
   logic [15:0] mod_reg, mod_next; // modulo value
   logic inh_reg, inh_next; // overflow inhibit
   logic [7:0] latch_reg, latch_next; // held low byte
   logic held_reg, held_next; // low byte is held
   tbu_ch_t ch_reg [2]; // channel controls
   tbu_ch_t ch_next [2];
   logic [15:0] cv_reg [2]; // channel values
   logic [15:0] cv_next [2];
   logic [2:0] arm_reg, arm_next; // first clear step done
   logic [1:0] pin_reg, pin_next; // last pin levels
   logic ack_reg, ack_next; // bus answer
   logic [31:0] dat_reg, dat_next; // read data

   //-----------------------------------------------------------
   // decode
   //-----------------------------------------------------------
   logic req; // request present
   logic acc; // access completes this edge
   logic wr; // byte write completes
   logic rd; // read completes
   logic [7:0] wd; // written byte
   logic freeze; // flags protected in break
   logic run; // counter may advance
   logic tick; // prescaled counter clock
   logic [15:0] cnt_inc; // next count value
   logic ovf_evt; // overflow event
   logic [2:0] evt; // flag set events
   logic [2:0] wr_f; // write to a flag register
   logic [2:0] rd_f; // read of a flag register
   logic [2:0] flag_q; // current flags
   logic [2:0] flag_d; // next flags
   logic rst_wr; // counter reset written
   logic rd_take; // read request seen, answer comes next edge

   // mask of prescaler bits that must be all ones
   function automatic logic [TBU_PW-1:0] ps_mask(
      input logic [2:0] ps
   );
      logic [TBU_PW:0] m;
      m = (7'h01 << ps) - 7'h01;
      ps_mask = m[TBU_PW-1:0];
   endfunction

   assign req = i_wb_cyc & i_wb_stb;
   // effects happen on the edge where ack is seen
   assign acc = req & ack_reg;
   assign wr = acc & i_wb_we & i_wb_sel[0];
   assign rd = acc & ~i_wb_we;
   // read side effects follow the byte the slave samples for the answer
   assign rd_take = req & ~ack_reg & ~i_wb_we;
   assign wd = i_wb_dat[7:0];
   assign rst_wr = wr & (i_wb_adr == TBU_A_SC) & wd[TBU_B_RST];
   // with clear-enable high, flag clearing in break behaves as normal; the counter still stops
   assign freeze = i_break & ~i_break_clear_enable; // RULE6 RULE7
   assign run = ~sc_reg.halt & ~i_stop & ~i_break; // RULE4 RULE5 RULE9
   // code 111 never ticks: no source behind it
   assign tick = run & (sc_reg.ps != TBU_PS_UNUSED) &
      ((presc_reg & ps_mask(sc_reg.ps)) == ps_mask(sc_reg.ps)); // RULE13
   // wrap at modulo so the match value is held one tick
   assign cnt_inc = (cnt_reg == mod_reg) ? TBU_CNT_ZERO :
      16'(cnt_reg + 16'h0001); // RULE16 RULE25
   assign ovf_evt = tick & (cnt_inc == mod_reg) & ~inh_reg; // RULE1 RULE17
   assign flag_q = {ch_reg[1].flag, ch_reg[0].flag, sc_reg.flag};
   assign wr_f = {3{wr}} & {i_wb_adr == TBU_A_CH1SC,
      i_wb_adr == TBU_A_CH0SC, i_wb_adr == TBU_A_SC};
   // arming sees the same flag value that the read returns, so an event
   // landing while the answer is pending can never be cleared unseen
   assign rd_f = {3{rd_take}} & {i_wb_adr == TBU_A_CH1SC,
      i_wb_adr == TBU_A_CH0SC, i_wb_adr == TBU_A_SC};

   //-----------------------------------------------------------
   // channel events
   //-----------------------------------------------------------
   assign evt[0] = ovf_evt;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         logic en; // channel usable
         logic cap; // capture mode
         logic cmp; // compare mode
         logic edg; // selected edge seen
         // buffered pairing borrows channel 1
         assign en = (g == 0) | ~ch_reg[0].buf_mode; // RULE21
         assign cap = en & ~ch_reg[g].buf_mode & ~ch_reg[g].mode_a &
            (ch_reg[g].edge_sel != 2'h0); // RULE21
         assign cmp = en & (ch_reg[g].mode_a | ch_reg[g].buf_mode);
         // edge select 01 rising, 10 falling, 11 both
         assign edg = (ch_reg[g].edge_sel[0] & i_channel_pin[g] &
            ~pin_reg[g]) | (ch_reg[g].edge_sel[1] &
            ~i_channel_pin[g] & pin_reg[g]);
         // halt, stop and break all block captures
         assign evt[g+1] = (cap & edg & run) |
            (cmp & tick & (cnt_inc == cv_reg[g])); // RULE19 RULE10 RULE5
      end
   endgenerate

   //-----------------------------------------------------------
   // core next state
   //-----------------------------------------------------------
   always_comb begin
      logic f;
      logic a;
      f = 1'b0;
      a = 1'b0;
      sc_next = sc_reg;
      cnt_next = cnt_reg;
      presc_next = presc_reg;
      mod_next = mod_reg;
      inh_next = inh_reg;
      latch_next = latch_reg;
      held_next = held_reg;
      ch_next = ch_reg;
      cv_next = cv_reg;
      pin_next = i_channel_pin;
      // prescaler free runs while counting allowed
      if (run) begin
         presc_next = TBU_PW'(presc_reg + 1'b1);
      end
      if (tick) begin
         cnt_next = cnt_inc; // RULE25 RULE16
      end
      // a capture stores the running count
      for (int i = 0; i < 2; i++) begin
         if (evt[i+1] && !ch_reg[i].mode_a && !ch_reg[i].buf_mode) begin
            cv_next[i] = cnt_reg;
         end
      end
      // two-step clearing; a new event always wins
      for (int k = 0; k < 3; k++) begin
         f = flag_q[k];
         a = arm_reg[k];
         if (rd_f[k] && f && !freeze) begin
            a = 1'b1; // RULE8 RULE20
         end
         // arm survives a frozen break for later use
         if (wr_f[k] && !freeze) begin
            if (a && !wd[TBU_B_FLAG]) begin
               f = 1'b0; // RULE8 RULE20 RULE7
            end
            a = 1'b0;
         end
         if (evt[k]) begin
            f = 1'b1; // RULE1 RULE19
            a = 1'b0;
         end
         flag_d[k] = f;
         arm_next[k] = a;
      end
      // counter register reads
      // latch on the edge that samples the high byte: a carry between
      // the take edge and the ack edge would otherwise split the pair
      if (rd_take && i_wb_adr == TBU_A_CNTH && !held_reg) begin
         latch_next = cnt_reg[7:0]; // RULE14
         held_next = 1'b1;
      end
      if (rd && i_wb_adr == TBU_A_CNTL) begin
         held_next = 1'b0; // RULE14
      end
      // register writes
      if (wr) begin
         unique case (i_wb_adr)
            TBU_A_SC: begin
               sc_next.irq_en = wd[6];
               sc_next.halt = wd[TBU_B_HALT]; // RULE9
               sc_next.ps = wd[2:0]; // RULE13
            end
            TBU_A_MODH: begin
               mod_next[15:8] = wd;
               inh_next = 1'b1; // RULE17
            end
            TBU_A_MODL: begin
               mod_next[7:0] = wd;
               inh_next = 1'b0; // RULE17
            end
            TBU_A_CH0SC: begin
               ch_next[0][6:0] = wd[6:0]; // RULE21
            end
            TBU_A_CH1SC: begin
               // channel 1 has no buffered mode bit
               ch_next[1][6:0] = {wd[6], 1'b0, wd[4:0]};
            end
            TBU_A_CH0H: cv_next[0][15:8] = wd;
            TBU_A_CH0L: cv_next[0][7:0] = wd;
            TBU_A_CH1H: cv_next[1][15:8] = wd;
            TBU_A_CH1L: cv_next[1][7:0] = wd;
            default: begin
               // read-only or unmapped: ignored
            end
         endcase
      end
      // reset bit is never stored, so it reads zero
      if (rst_wr) begin
         cnt_next = TBU_CNT_ZERO; // RULE11 RULE12 RULE15
         presc_next = '0; // RULE11
         held_next = 1'b0;
      end
      sc_next.flag = flag_d[0];
      ch_next[0].flag = flag_d[1];
      ch_next[1].flag = flag_d[2];
   end

   //-----------------------------------------------------------
   // core registers
   //-----------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         sc_reg <= TBU_SC_RESET; // RULE9 RULE13
         cnt_reg <= TBU_CNT_ZERO; // RULE15
         presc_reg <= '0;
         mod_reg <= TBU_MOD_RESET; // RULE18
         inh_reg <= 1'b0;
         latch_reg <= 8'h00;
         held_reg <= 1'b0;
         ch_reg[0] <= TBU_CH_RESET; // RULE24
         ch_reg[1] <= TBU_CH_RESET; // RULE24
         cv_reg[0] <= TBU_CNT_ZERO;
         cv_reg[1] <= TBU_CNT_ZERO;
         arm_reg <= 3'h0;
         pin_reg <= 2'h0;
      end else begin
         sc_reg <= sc_next;
         cnt_reg <= cnt_next;
         presc_reg <= presc_next;
         mod_reg <= mod_next;
         inh_reg <= inh_next;
         latch_reg <= latch_next;
         held_reg <= held_next;
         ch_reg <= ch_next;
         cv_reg <= cv_next;
         arm_reg <= arm_next;
         pin_reg <= pin_next;
      end
   end

   //-----------------------------------------------------------
   // bus slave
   //-----------------------------------------------------------
   // one wait state; data is captured before the ack edge
   always_comb begin
      logic [7:0] b;
      b = 8'h00;
      ack_next = req & ~ack_reg;
      dat_next = dat_reg;
      unique case (i_wb_adr)
         TBU_A_SC: b = sc_reg;
         TBU_A_CNTH: b = cnt_reg[15:8];
         TBU_A_CNTL: b = held_reg ? latch_reg : cnt_reg[7:0]; // RULE14
         TBU_A_MODH: b = mod_reg[15:8];
         TBU_A_MODL: b = mod_reg[7:0];
         TBU_A_CH0SC: b = ch_reg[0];
         TBU_A_CH1SC: b = ch_reg[1];
         TBU_A_CH0H: b = cv_reg[0][15:8];
         TBU_A_CH0L: b = cv_reg[0][7:0];
         TBU_A_CH1H: b = cv_reg[1][15:8];
         TBU_A_CH1L: b = cv_reg[1][7:0];
         default: b = 8'h00; // unmapped reads as zero
      endcase
      if (req && !ack_reg) begin
         dat_next = {24'h000000, b};
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end

   //-----------------------------------------------------------
   // outputs
   //-----------------------------------------------------------
   assign o_wb_ack = ack_reg;
   assign o_wb_dat = dat_reg;
   // level requests, held until flag or enable drops
   assign o_overflow_irq = sc_reg.flag & sc_reg.irq_en; // RULE1 RULE26
   assign o_channel_irq[0] = ch_reg[0].flag & ch_reg[0].irq_en; // RULE2
   assign o_channel_irq[1] = ch_reg[1].flag & ch_reg[1].irq_en; // RULE26
   // any enabled request wakes a waiting core
   assign o_wakeup = o_overflow_irq | (|o_channel_irq); // RULE3

   //-----------------------------------------------------------
   // assertions
   //-----------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   sequence s_rst_halt;
      (rst_wr && wd[TBU_B_HALT]) ##1 (sc_reg.halt && !i_break)[*3];
   endsequence

   ovf_set_cause_a: assert property ( // RULE1
      $rose(sc_reg.flag) |-> $past(ovf_evt))
      else $error("overflow flag rose without overflow");
   ch_irq_gate_a: assert property ( // RULE2
      $rose(o_channel_irq[0]) |-> $past(evt[1]) || $rose(ch_reg[0].irq_en))
      else $error("channel irq without event or enable");
   stop_hold_a: assert property ( // RULE4
      (i_stop && !acc) |=> $stable(cnt_reg) && $stable(presc_reg))
      else $error("counter moved in stop mode");
   break_hold_a: assert property ( // RULE5
      (i_break && !rst_wr) |=> $stable(cnt_reg))
      else $error("counter moved during break");
   break_protect_a: assert property ( // RULE6
      freeze |=> !$fell(sc_reg.flag) && !$fell(ch_reg[0].flag))
      else $error("flag cleared while protected");
   clear_armed_a: assert property ( // RULE8
      $fell(sc_reg.flag) |-> $past(arm_reg[0]) && $past(wr_f[0]))
      else $error("overflow flag cleared without read");
   ch0_clear_a: assert property ( // RULE20
      $fell(ch_reg[0].flag) |-> $past(arm_reg[1]) && $past(wr_f[1]))
      else $error("channel 0 flag cleared without read");
   ch1_clear_a: assert property ( // RULE20
      $fell(ch_reg[1].flag) |-> $past(arm_reg[2]) && $past(wr_f[2]))
      else $error("channel 1 flag cleared without read");
   irq_level_a: assert property ( // RULE26
      (o_overflow_irq && !wr_f[0]) |=> o_overflow_irq)
      else $error("overflow request dropped without a write");
   halt_hold_a: assert property ( // RULE9
      (sc_reg.halt && !rst_wr) |=> $stable(cnt_reg))
      else $error("counter moved while halted");
   halt_cap_a: assert property ( // RULE10
      sc_reg.halt |=> !$rose(ch_reg[0].flag) && !$rose(ch_reg[1].flag))
      else $error("capture while halted");
   rst_clear_a: assert property ( // RULE11
      rst_wr |=> cnt_reg == TBU_CNT_ZERO && presc_reg == '0)
      else $error("counter reset did not clear");
   rst_halt_a: assert property ( // RULE12
      s_rst_halt |-> cnt_reg == TBU_CNT_ZERO)
      else $error("halted counter left zero");
   mod_wrap_a: assert property ( // RULE16
      (tick && cnt_reg == mod_reg) |=> cnt_reg == TBU_CNT_ZERO)
      else $error("counter did not wrap at modulo");
   mod_inhibit_a: assert property ( // RULE17
      inh_reg |=> !$rose(sc_reg.flag))
      else $error("overflow set while modulo half written");
   latch_keep_a: assert property ( // RULE14
      (held_reg && !rst_wr && !(rd && i_wb_adr == TBU_A_CNTL))
      |=> $stable(latch_reg) && held_reg)
      else $error("held low byte changed");

endmodule
`default_nettype wire

// ==== verif/tbu_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// far side: two channel pin sources
// ------------------------------------------------
module tbu_pin_model (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [1:0] i_toggle,
   output logic [1:0] o_channel_pin
);
   logic [1:0] pin_reg; // driven levels, low out of reset
   logic [1:0] pin_next; // levels after the requested edges
   // one request gives exactly one clean edge on each chosen pin
   always_comb begin
      pin_next = pin_reg ^ i_toggle;
   end
   // change on the bus clock only, so no edge is half seen
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_reg <= 2'h0;
      end else begin
         pin_reg <= pin_next;
      end
   end
   assign o_channel_pin = pin_reg;
endmodule
`default_nettype wire

// ==== verif/tbu_timer_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module tbu_timer_bench;
   import tbu_pkg::*;
   // ------------------------------------------------
   // signals
   // ------------------------------------------------
   logic clk, rstn, cyc, stb, we, stp, brk, bce; // driven controls
   logic [7:0] adr, rd, hi, lo; // bus address, last read byte
   logic [31:0] wdat, rdat;
   logic ack, ovf, wake;
   logic [1:0] chirq, pins, tog; // channel irqs, pin levels
   logic [15:0] c, c2; // counter snapshots
   int bad_count, cmp_count;
   typedef struct packed {
      logic [7:0] adr;
      logic [7:0] exp;
   } tbu_row_t;
   // reset view of the map; the last slot is unmapped
   tbu_row_t rows [8] = '{'{TBU_A_SC, 8'h20}, '{TBU_A_CNTH, 8'h00},
      '{TBU_A_CNTL, 8'h00}, '{TBU_A_MODH, 8'hFF}, '{TBU_A_MODL, 8'hFF},
      '{TBU_A_CH0SC, 8'h00}, '{TBU_A_CH1SC, 8'h00}, '{8'h3C, 8'h00}};
   tbu_timer u_tbu_timer (
      .i_clock(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_stop(stp), .i_break(brk),
      .i_break_clear_enable(bce), .i_channel_pin(pins),
      .o_overflow_irq(ovf), .o_channel_irq(chirq), .o_wakeup(wake));
   tbu_pin_model u_tbu_pin_model (.i_clock(clk), .i_resetn(rstn),
      .i_toggle(tog), .o_channel_pin(pins));
   // 40 MHz bus clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ------------------------------------------------
   // tasks
   // ------------------------------------------------
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t byte %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t level %b want %b", $time, got, exp);
      end
   endtask
   // counts are checked in a window: the start phase is not pinned
   task automatic chkn(input logic [15:0] got, input int exp, input int tol);
      cmp_count++;
      if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol)
      begin
         bad_count++;
         $display("[FAIL] %0t count %0d want %0d", $time, got, exp);
      end
   endtask
   // classic single cycle; holds everything until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         $display("[FAIL] %0t bus timeout", $time);
         stop_test();
      end
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(negedge clk); // outputs settled for the caller
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // high byte first so the low byte comes from the latch
   task automatic rd_cnt(output logic [15:0] v);
      wb(1'b0, TBU_A_CNTH, 8'h00);
      hi = rd;
      wb(1'b0, TBU_A_CNTL, 8'h00);
      lo = rd;
      v = {hi, lo};
   endtask
   task automatic ctl(input logic s, input logic b, input logic e);
      @(posedge clk);
      stp <= s;
      brk <= b;
      bce <= e;
      @(negedge clk);
   endtask
   task automatic pin_edge(input logic [1:0] m);
      @(posedge clk);
      tog <= m;
      @(posedge clk);
      tog <= 2'h0;
      ticks(4);
   endtask
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      rstn = 1'b0;
      {cyc, stb, we, stp, brk, bce} = 6'h00;
      adr = 8'h00;
      wdat = 32'h0;
      tog = 2'h0;
      bad_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         wb(1'b0, rows[i].adr, 8'h00);
         chk8(rd, rows[i].exp);
      end
      $display("reset map done");
      // every prescale code over a fixed window of 131 bus cycles
      for (int ps = 0; ps < 8; ps++) begin
         wb(1'b1, TBU_A_SC, 8'h30 | 8'(ps));
         rd_cnt(c);
         chkn(c, 0, 0);
         wb(1'b1, TBU_A_SC, 8'h10 | 8'(ps));
         ticks(128);
         wb(1'b1, TBU_A_SC, 8'h20 | 8'(ps));
         rd_cnt(c);
         chkn(c, (ps == 7) ? 0 : 131 >> ps, (ps == 7) ? 0 : 2);
         rd_cnt(c2);
         chkn(c2, int'(c), 0);
         wb(1'b0, TBU_A_SC, 8'h00);
         chk8(rd, 8'h20 | 8'(ps));
      end
      $display("prescaler done");
      // overflow at modulo 0x0100, reset before the modulo write
      wb(1'b1, TBU_A_SC, 8'h30);
      wb(1'b1, TBU_A_MODH, 8'h01);
      wb(1'b1, TBU_A_MODL, 8'h00);
      wb(1'b1, TBU_A_SC, 8'h40);
      ticks(300);
      chk1(ovf, 1'b1);
      chk1(wake, 1'b1);
      rd_cnt(c);
      chkn(c, 46, 4);
      wb(1'b1, TBU_A_SC, 8'hC0);
      chk1(ovf, 1'b1);
      wb(1'b0, TBU_A_SC, 8'h00);
      chk8(rd, 8'hC0);
      wb(1'b1, TBU_A_SC, 8'h40);
      chk1(ovf, 1'b0);
      chk1(wake, 1'b0);
      wb(1'b1, TBU_A_SC, 8'h00);
      ticks(300);
      chk1(ovf, 1'b0);
      wb(1'b0, TBU_A_SC, 8'h00);
      chk8(rd, 8'h80);
      wb(1'b1, TBU_A_SC, 8'hC0);
      chk1(ovf, 1'b1);
      wb(1'b0, TBU_A_SC, 8'h00);
      ticks(300); // a fresh overflow lands between the two steps
      wb(1'b1, TBU_A_SC, 8'h40);
      chk1(ovf, 1'b1);
      wb(1'b0, TBU_A_SC, 8'h00);
      wb(1'b1, TBU_A_SC, 8'h40);
      wb(1'b1, TBU_A_MODH, 8'h01);
      ticks(300);
      chk1(ovf, 1'b0);
      wb(1'b1, TBU_A_MODL, 8'h00);
      ticks(300);
      chk1(ovf, 1'b1);
      $display("overflow done");
      // break with clear protection, then with clearing allowed
      wb(1'b0, TBU_A_SC, 8'h00);
      ctl(1'b0, 1'b1, 1'b0);
      rd_cnt(c);
      ticks(50);
      rd_cnt(c2);
      chkn(c2, int'(c), 0);
      wb(1'b1, TBU_A_SC, 8'h40);
      chk1(ovf, 1'b1);
      ctl(1'b0, 1'b0, 1'b0);
      wb(1'b1, TBU_A_SC, 8'h40);
      chk1(ovf, 1'b0);
      ticks(300);
      ctl(1'b0, 1'b1, 1'b1);
      wb(1'b0, TBU_A_SC, 8'h00);
      wb(1'b1, TBU_A_SC, 8'h40);
      ctl(1'b0, 1'b0, 1'b0);
      chk1(ovf, 1'b0);
      // stop mode: about 8 counts outside a 100 cycle stop
      wb(1'b1, TBU_A_SC, 8'h10);
      rd_cnt(c);
      ctl(1'b1, 1'b0, 1'b0);
      ticks(100);
      ctl(1'b0, 1'b0, 1'b0);
      rd_cnt(c2);
      chkn(c2 - c, 8, 3);
      $display("break and stop done");
      // channels: capture edges, gating, inhibit, compare
      wb(1'b1, TBU_A_CH0SC, 8'h44);
      wb(1'b1, TBU_A_CH1SC, 8'h08);
      pin_edge(2'h3);
      chk1(chirq[0], 1'b1);
      wb(1'b0, TBU_A_CH1SC, 8'h00);
      chk8(rd, 8'h08);
      pin_edge(2'h3);
      wb(1'b0, TBU_A_CH1SC, 8'h00);
      chk8(rd, 8'h88);
      chk1(chirq[1], 1'b0);
      wb(1'b1, TBU_A_CH1SC, 8'h08);
      wb(1'b0, TBU_A_CH0SC, 8'h00);
      wb(1'b1, TBU_A_CH0SC, 8'h44);
      chk1(chirq[0], 1'b0);
      wb(1'b1, TBU_A_SC, 8'h20);
      pin_edge(2'h1);
      wb(1'b0, TBU_A_CH0SC, 8'h00);
      chk8(rd, 8'h44);
      wb(1'b1, TBU_A_SC, 8'h00);
      pin_edge(2'h1);
      ctl(1'b0, 1'b1, 1'b0);
      pin_edge(2'h1);
      wb(1'b0, TBU_A_CH0SC, 8'h00);
      chk8(rd, 8'h44);
      ctl(1'b0, 1'b0, 1'b0);
      pin_edge(2'h1);
      pin_edge(2'h1);
      wb(1'b0, TBU_A_CH0SC, 8'h00);
      chk8(rd, 8'hC4);
      wb(1'b1, TBU_A_CH1H, 8'h00);
      wb(1'b1, TBU_A_CH1L, 8'h40);
      wb(1'b1, TBU_A_CH1SC, 8'h50);
      chk1(chirq[1], 1'b0);
      ticks(300);
      chk1(chirq[1], 1'b1);
      $display("channels done");
      // flag found while halted: unhalt, clear, then halt again
      wb(1'b1, TBU_A_SC, 8'h20);
      wb(1'b0, TBU_A_SC, 8'h00);
      chk8(rd, 8'hA0);
      wb(1'b1, TBU_A_SC, 8'h90);
      wb(1'b0, TBU_A_SC, 8'h00);
      wb(1'b1, TBU_A_SC, 8'h00);
      wb(1'b1, TBU_A_SC, 8'h20);
      wb(1'b0, TBU_A_SC, 8'h00);
      chk8(rd, 8'h20);
      $display("halted flag done");
      stop_test();
   end
endmodule
`default_nettype wire
